// *** qwr_flash_read.sv ***
// Purpose: quad and dual-edge read sequencer of a serial NOR flash, device side
// Assumes: array read port answers i_mem_data in the same cycle as o_mem_addr
// Notes:   serial clock is oversampled; it must stay below a quarter of i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module qwr_flash_read #(
  parameter int P_DC1_DUMMY = 7
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_sclk,
  input  wire logic                       i_cs_n,
  input  wire logic [qwr_pkg::IO_W-1:0]   i_io,
  output logic      [qwr_pkg::IO_W-1:0]   o_io,
  output logic      [qwr_pkg::IO_W-1:0]   o_io_oe,
  input  wire logic                       i_quad_lines_enable_bit,
  input  wire logic                       i_dummy_count_select_bit,
  input  wire logic [qwr_pkg::DATA_W-1:0] i_mem_data,
  output logic      [qwr_pkg::ADDR_W-1:0] o_mem_addr,
  output logic                            o_quad_command_mode,
  output logic                            o_opcode_skip_armed,
  output logic                            o_wrap_disable_bit,
  output logic      [1:0]                 o_wrap_length_bits,
  output logic      [1:0]                 o_quad_dummy_count_field
);
  import qwr_pkg::*;

  if (P_DC1_DUMMY < 1 || P_DC1_DUMMY > 63) begin : g_chk
    $error("qwr_flash_read: P_DC1_DUMMY must be 1..63");
  end

  localparam logic [5:0] DC1_DUMMY = 6'(P_DC1_DUMMY);

  // pin conditioning: {io, cs_n, sclk} share one synchroniser
  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_rise;
  logic [PIN_W-1:0] pin_fall;
  qwr_pin_sync #(.W(PIN_W), .P_IDLE(PIN_IDLE)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     ({i_io, i_cs_n, i_sclk}),
    .o_level   (pin_lvl),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  logic            sck_r;
  logic            sck_f;
  logic            cs_start;
  logic            cs_end;
  logic [IO_W-1:0] io_in;
  assign sck_r    = pin_rise[0];
  assign sck_f    = pin_fall[0];
  assign cs_start = pin_fall[1];
  assign cs_end   = pin_rise[1];
  assign io_in    = pin_lvl[PIN_W-1:2];

  qwr_state_e        st;
  qwr_state_e        next_st;
  logic [7:0]        cmd;
  logic [7:0]        sh;
  logic [5:0]        cnt;
  logic [ADDR_W-1:0] addr;
  logic              cont;
  logic [7:0]        cont_cmd;
  logic              quad_command_mode;
  logic              wrap_dis;
  logic [1:0]        wrap_len;
  logic [1:0]        dum_field;
  logic              nib_hi;

  // decode helpers
  logic       dtr;
  logic       has_mode;
  logic       in_ev;
  logic       out_ev;
  logic       adv;
  logic       cmd_last;
  logic [7:0] nib_byte;
  logic [7:0] bit_byte;
  logic [7:0] op_byte;
  logic [5:0] qpi_dum;
  logic [5:0] dum_need;

  assign dtr      = (cmd == OP_DTR_QIO) || (cmd == OP_DTR_WRAP);
  assign has_mode = (cmd == OP_DTR_QIO) || (cmd == OP_WORD_RD);
  // dual-edge phases start on a rise; the fall closing the last opcode clock is no address edge
  assign in_ev    = (dtr && (st == ST_ADDR || st == ST_MODE)) ? (cnt[0] ? sck_f : sck_r) : sck_r;
  assign out_ev   = (st == ST_DATA) && (dtr ? (sck_r | sck_f) : sck_f);
  assign adv      = (st == ST_DUMMY) ? sck_r : in_ev;
  assign cmd_last = cnt == (quad_command_mode ? QPI_CMD_LAST : SPI_CMD_LAST);
  assign nib_byte = {sh[3:0], io_in};
  assign bit_byte = {sh[6:0], io_in[0]};
  assign op_byte  = quad_command_mode ? nib_byte : bit_byte;

  // dummy count of quad command mode from the parameter field
  always_comb begin
    case (dum_field)
      2'h0:    qpi_dum = DUMMY_P00;
      2'h1:    qpi_dum = DUMMY_P01;
      2'h2:    qpi_dum = DUMMY_P10;
      2'h3:    qpi_dum = DUMMY_P11;
      default: qpi_dum = DUMMY_P00;
    endcase
  end

  // dummies that follow the mode byte, or the address where there is none; in quad command mode the DTR mode clock is one of them
  always_comb begin
    case (cmd)
      OP_DTR_QIO: dum_need = quad_command_mode ? (qpi_dum - 6'h01)
                                 : (i_dummy_count_select_bit ? DC1_DUMMY : SPI_DTR_DUMMY);
      OP_WORD_RD: dum_need = WORD_DUMMY;
      default:    dum_need = qpi_dum;
    endcase
  end

  // frame sequencer
  always_comb begin
    next_st = st;
    case (st)
      ST_IDLE: begin
        if (cs_start) begin
          next_st = cont ? ST_ADDR : ST_CMD;
        end
      end
      ST_CMD: begin
        if (in_ev && cmd_last) begin
          case (op_byte)
            OP_DTR_QIO:   next_st = i_quad_lines_enable_bit ? ST_ADDR : ST_IGN;
            OP_WORD_RD:   next_st = (i_quad_lines_enable_bit && !quad_command_mode) ? ST_ADDR : ST_IGN;
            OP_SET_WRAP:  next_st = quad_command_mode ? ST_IGN : ST_WCFG;
            OP_SET_PARAM: next_st = quad_command_mode ? ST_PARAM : ST_IGN;
            OP_BURST_WRAP,
            OP_DTR_WRAP:  next_st = quad_command_mode ? ST_ADDR : ST_IGN;
            default:      next_st = ST_IGN;
          endcase
        end
      end
      ST_ADDR: begin
        if (in_ev && cnt == ADDR_LAST) begin
          next_st = has_mode ? ST_MODE : ST_DUMMY;
        end
      end
      ST_MODE: begin
        if (in_ev && cnt == PAIR_LAST) begin
          next_st = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (sck_r && cnt == dum_need - 6'h01) begin
          next_st = ST_DATA;
        end
      end
      ST_WCFG: begin
        if (in_ev && cnt == WCFG_LAST) begin
          next_st = ST_IGN;
        end
      end
      ST_PARAM: begin
        if (in_ev && cnt == PAIR_LAST) begin
          next_st = ST_IGN;
        end
      end
      ST_DATA, ST_IGN: begin
        next_st = st;
      end
      default: next_st = ST_IDLE;
    endcase
    if (cs_end) begin
      next_st = ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // phase counter restarts on every state change
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || next_st != st) begin
      cnt <= 6'h00;
    end else if (adv) begin
      cnt <= cnt + 6'h01;
    end
  end

  // shift register for opcode, mode, wrap and parameter bytes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sh <= 8'h00;
    end else if (in_ev && (st == ST_CMD || st == ST_MODE || st == ST_WCFG || st == ST_PARAM)) begin
      sh <= (quad_command_mode || st == ST_MODE) ? nib_byte : bit_byte;
    end
  end

  // opcode of the frame; a skipped opcode is replayed from the armed one
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd <= 8'h00;
    end else if (st == ST_CMD && in_ev && cmd_last) begin
      cmd <= op_byte;
    end else if (st == ST_IDLE && cs_start && cont) begin
      cmd <= cont_cmd;
    end
  end

  // continuous mode: only bits 5:4 of the mode byte are looked at
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cont     <= 1'b0;
      cont_cmd <= 8'h00;
    end else if (st == ST_MODE && in_ev && cnt == PAIR_LAST) begin
      cont     <= nib_byte[SKIP_POS +: 2] == CONT_KEEP;
      cont_cmd <= cmd;
    end
  end

  // command mode switch; entry needs quad enable
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      quad_command_mode <= 1'b0;
    end else if (st == ST_CMD && in_ev && cmd_last) begin
      if (op_byte == OP_QPI_ON && i_quad_lines_enable_bit) begin
        quad_command_mode <= 1'b1;
      end else if (op_byte == OP_QPI_OFF && quad_command_mode) begin
        quad_command_mode <= 1'b0;
      end
    end
  end

  // wrap length is one register so it survives a mode switch
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wrap_dis  <= RST_WRAP_DIS;
      wrap_len  <= RST_WRAP_LEN;
      dum_field <= RST_DUM_FIELD;
    end else if (st == ST_WCFG && in_ev && cnt == WCFG_LAST) begin
      wrap_dis  <= bit_byte[WRAP_DIS_POS];
      wrap_len  <= bit_byte[WRAP_LEN_POS +: 2];
    end else if (st == ST_PARAM && in_ev && cnt == PAIR_LAST) begin
      dum_field <= nib_byte[PARAM_DUM_POS +: 2];
      wrap_len  <= nib_byte[PARAM_LEN_POS +: 2];
    end
  end

  // wrap applies to SPI-mode quad reads after a burst setting, and to burst wrap reads
  qwr_wrap_if wif ();
  assign wif.addr    = addr;
  assign wif.len_sel = wrap_len;
  assign wif.wrap_on = ((cmd == OP_DTR_QIO || cmd == OP_WORD_RD) && !quad_command_mode && !wrap_dis)
                     || cmd == OP_BURST_WRAP || cmd == OP_DTR_WRAP;
  qwr_wrap_calc u_wrap (
    .w (wif)
  );

  // address shifts in by nibble, then steps after each low nibble out
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      addr <= '0;
    end else if (st == ST_ADDR && in_ev) begin
      addr <= {addr[ADDR_W-5:0], io_in};
    end else if (out_ev && !nib_hi && !cs_end) begin
      addr <= wif.next_addr;
    end
  end

  // data out, high nibble first; drivers off as soon as the frame ends
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_io    <= 4'h0;
      o_io_oe <= 4'h0;
      nib_hi  <= 1'b1;
    end else if (st != ST_DATA || cs_end) begin
      o_io_oe <= 4'h0;
      nib_hi  <= 1'b1;
    end else if (out_ev) begin
      o_io    <= nib_hi ? i_mem_data[7:4] : i_mem_data[3:0];
      o_io_oe <= 4'hF;
      nib_hi  <= !nib_hi;
    end
  end

  assign o_mem_addr               = addr;
  assign o_quad_command_mode      = quad_command_mode;
  assign o_opcode_skip_armed      = cont;
  assign o_wrap_disable_bit       = wrap_dis;
  assign o_wrap_length_bits       = wrap_len;
  assign o_quad_dummy_count_field = dum_field;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_dtr_needs_qe;
    (st == ST_ADDR && $past(st) == ST_CMD && cmd == OP_DTR_QIO) |-> $past(i_quad_lines_enable_bit);
  endproperty
  a_dtr_needs_qe: assert property (p_dtr_needs_qe) else $error("quad read started without quad enable");

  property p_drive_only_data;
    (o_io_oe != 4'h0) |-> (st == ST_DATA);
  endproperty
  a_drive_only_data: assert property (p_drive_only_data) else $error("io driven outside data phase");

  property p_skip_opcode;
    (st == ST_IDLE && cs_start && cont) |=> (st == ST_ADDR && cmd == $past(cont_cmd));
  endproperty
  a_skip_opcode: assert property (p_skip_opcode) else $error("armed frame did not skip opcode");

  property p_need_opcode;
    (st == ST_IDLE && cs_start && !cont) |=> (st == ST_CMD);
  endproperty
  a_need_opcode: assert property (p_need_opcode) else $error("unarmed frame skipped opcode");

  property p_spi_dtr_dummy;
    (st == ST_DATA && $past(st) == ST_DUMMY && cmd == OP_DTR_QIO && !quad_command_mode && !i_dummy_count_select_bit)
      |-> $past(cnt) == 6'h06;
  endproperty
  a_spi_dtr_dummy: assert property (p_spi_dtr_dummy) else $error("DTR read dummy count not seven");

  property p_word_dummy;
    (st == ST_DATA && $past(st) == ST_DUMMY && cmd == OP_WORD_RD) |-> $past(cnt) == 6'h01;
  endproperty
  a_word_dummy: assert property (p_word_dummy) else $error("word read dummy count not two");

  property p_qpi_dummy;
    (st == ST_DATA && $past(st) == ST_DUMMY && cmd == OP_BURST_WRAP) |->
      ($past(cnt) + 6'h01) == (dum_field == 2'h0 ? 6'h0A : dum_field == 2'h1 ? 6'h04 :
                               dum_field == 2'h2 ? 6'h06 : 6'h08);
  endproperty
  a_qpi_dummy: assert property (p_qpi_dummy) else $error("burst wrap dummy count wrong");

  property p_wrap_in_section;
    (st == ST_DATA && $past(st) == ST_DATA && wif.wrap_on) |-> addr[ADDR_W-1:6] == $past(addr[ADDR_W-1:6]);
  endproperty
  a_wrap_in_section: assert property (p_wrap_in_section) else $error("wrapped read left its section");

  property p_qpi_no_wrap;
    (quad_command_mode && cmd == OP_DTR_QIO && st == ST_DATA) |-> !wif.wrap_on;
  endproperty
  a_qpi_no_wrap: assert property (p_qpi_no_wrap) else $error("quad mode DTR read wraps");

  property p_qpi_entry;
    $rose(quad_command_mode) |-> $past(i_quad_lines_enable_bit) && $past(st) == ST_CMD;
  endproperty
  a_qpi_entry: assert property (p_qpi_entry) else $error("quad mode entered without enable");

  property p_param_in_qpi;
    (st == ST_PARAM) |-> quad_command_mode;
  endproperty
  a_param_in_qpi: assert property (p_param_in_qpi) else $error("parameter command taken in SPI mode");

  property p_reset_defaults;
    $past(i_rst) |-> (wrap_len == 2'h0 && dum_field == 2'h0 && wrap_dis && qpi_dum == 6'h0A);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");
endmodule
`default_nettype wire

// *** qwr_host_model.sv ***
// Purpose: behavioural host flash controller on the four-line link
// Assumes: 160 ns link period, data changed mid-half, away from edges
// Notes:   released line 3 churns every system clock; released lines 0 to 2 rest at 1, 0, 1
`timescale 1ns/1ps
`default_nettype none
module qwr_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [3:0] i_io,
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_io,
  output logic            o_drv
);
  logic [3:0] val;
  logic [3:0] pat = 4'h5;
  logic [7:0] rx_byte;
  event       got;

  // idle link: clock low, chip deselected, lines released
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_drv  = 1'b0;
    val    = 4'h0;
  end

  // only floating line 3 is kept from looking stable to the device
  always @(posedge i_sys_clk) pat <= ~pat + 4'h3;
  assign o_io = o_drv ? val : pat;

  // one half period; the clock stands still outside these calls
  task automatic half(input logic [3:0] v, input logic d);
    val = v;
    o_drv = d;
    #40 o_sclk = ~o_sclk;
    #40;
  endtask

  // open or close a frame, always with the clock parked low
  task automatic frame(input logic lo);
    if (o_sclk) half(4'h0, 1'b0);
    o_drv = 1'b0;
    #40 o_cs_n = ~lo;
    #200;
  endtask

  // sdr data is launched on falls only, dtr data on every edge
  task automatic rd(input int n, input logic dtr);
    for (int k = 0; k < (dtr ? 2 : 4) * n; k++) begin
      half(4'h0, 1'b0);
      if (dtr || k % 2 == 0) begin
        rx_byte = {rx_byte[3:0], i_io};
        if (dtr ? k % 2 == 1 : k % 4 == 2) -> got;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** qwr_pin_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter and edge pulses
// Assumes: pins are asynchronous to i_sys_clk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module qwr_pin_sync #(
  parameter int                       W      = qwr_pkg::PIN_W,
  parameter logic [qwr_pkg::PIN_W-1:0] P_IDLE = qwr_pkg::PIN_IDLE
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  import qwr_pkg::*;

  if (W < 1 || W > PIN_W) begin : g_chk
    $error("qwr_pin_sync: W out of range");
  end

  // one chain per pin; stage one feeds stage two only
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        s1         <= P_IDLE[i];
        s2         <= P_IDLE[i];
        s3         <= P_IDLE[i];
        o_level[i] <= P_IDLE[i];
        o_rise[i]  <= 1'b0;
        o_fall[i]  <= 1'b0;
      end else begin
        s1         <= i_pin[i];
        s2         <= s1;
        s3         <= s2;
        o_rise[i]  <= (s2 == s3) && s2 && !o_level[i];
        o_fall[i]  <= (s2 == s3) && !s2 && o_level[i];
        if (s2 == s3) begin
          o_level[i] <= s2;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** qwr_pkg.sv ***
// Purpose: shared constants and types of the quad read sequencer
// Assumes: 24-bit byte address, byte-wide array read port
// Notes:   one-hot state codes are written out
package qwr_pkg;

  // widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int IO_W   = 4;
  localparam int PIN_W  = 6;

  // opcodes
  localparam logic [7:0] OP_DTR_QIO    = 8'hED;
  localparam logic [7:0] OP_WORD_RD    = 8'hE7;
  localparam logic [7:0] OP_SET_WRAP   = 8'h77;
  localparam logic [7:0] OP_SET_PARAM  = 8'hC0;
  localparam logic [7:0] OP_BURST_WRAP = 8'h0C;
  localparam logic [7:0] OP_DTR_WRAP   = 8'h0E;
  localparam logic [7:0] OP_QPI_ON     = 8'h38;
  localparam logic [7:0] OP_QPI_OFF    = 8'hFF;

  // field positions and codes
  localparam int         SKIP_POS      = 4;
  localparam logic [1:0] CONT_KEEP     = 2'h2;
  localparam int         WRAP_DIS_POS  = 4;
  localparam int         WRAP_LEN_POS  = 5;
  localparam int         PARAM_DUM_POS = 4;
  localparam int         PARAM_LEN_POS = 0;

  // cycle counts, last index of each phase; the dummy entries are counts
  localparam logic [5:0] SPI_CMD_LAST  = 6'h07;
  localparam logic [5:0] QPI_CMD_LAST  = 6'h01;
  localparam logic [5:0] ADDR_LAST     = 6'h05;
  localparam logic [5:0] PAIR_LAST     = 6'h01;
  localparam logic [5:0] WCFG_LAST     = 6'h1F;
  localparam logic [5:0] SPI_DTR_DUMMY = 6'h07;
  localparam logic [5:0] WORD_DUMMY    = 6'h02;
  localparam logic [5:0] DUMMY_P00     = 6'h0A;
  localparam logic [5:0] DUMMY_P01     = 6'h04;
  localparam logic [5:0] DUMMY_P10     = 6'h06;
  localparam logic [5:0] DUMMY_P11     = 6'h08;

  // values after reset
  localparam logic       RST_WRAP_DIS  = 1'b1;
  localparam logic [1:0] RST_WRAP_LEN  = 2'h0;
  localparam logic [1:0] RST_DUM_FIELD = 2'h0;
  localparam logic [5:0] PIN_IDLE      = 6'h02;

  // wrap section masks, 8 to 64 bytes
  localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h000001;
  localparam logic [ADDR_W-1:0] MASK_8   = 24'h000007;
  localparam logic [ADDR_W-1:0] MASK_16  = 24'h00000F;
  localparam logic [ADDR_W-1:0] MASK_32  = 24'h00001F;
  localparam logic [ADDR_W-1:0] MASK_64  = 24'h00003F;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_CMD   = 9'h002,
    ST_ADDR  = 9'h004,
    ST_MODE  = 9'h008,
    ST_DUMMY = 9'h010,
    ST_DATA  = 9'h020,
    ST_WCFG  = 9'h040,
    ST_PARAM = 9'h080,
    ST_IGN   = 9'h100
  } qwr_state_e;

endpackage

// *** qwr_wrap_calc.sv ***
// Purpose: next byte address, linear or wrapped inside an aligned section
// Assumes: section of at most 64 bytes, so it never leaves a 256-byte page
// Notes:   linear mode rolls over at the top of the address space
`timescale 1ns/1ps
`default_nettype none
module qwr_wrap_calc (
  qwr_wrap_if.calc w
);
  import qwr_pkg::*;

  logic [ADDR_W-1:0] inc;
  logic [ADDR_W-1:0] mask;

  // keep the upper bits, let only the in-section bits count
  always_comb begin
    inc = w.addr + ADDR_ONE;
    case (w.len_sel)
      2'h0:    mask = MASK_8;
      2'h1:    mask = MASK_16;
      2'h2:    mask = MASK_32;
      2'h3:    mask = MASK_64;
      default: mask = MASK_8;
    endcase
    w.next_addr = w.wrap_on ? ((w.addr & ~mask) | (inc & mask)) : inc;
  end
endmodule
`default_nettype wire

// *** qwr_wrap_if.sv ***
// Purpose: carries the read address and wrap setting to the wrap calculator
// Assumes: purely combinational path
// Notes:   user drives, calc answers next_addr
`timescale 1ns/1ps
`default_nettype none
interface qwr_wrap_if;
  logic [qwr_pkg::ADDR_W-1:0] addr;
  logic                       wrap_on;
  logic [1:0]                 len_sel;
  logic [qwr_pkg::ADDR_W-1:0] next_addr;
  modport calc (input addr, input wrap_on, input len_sel, output next_addr);
  modport user (output addr, output wrap_on, output len_sel, input next_addr);
endinterface
`default_nettype wire

// *** tb_qwr_flash_read.sv ***
// Purpose: self-checking bench of the quad read sequencer
// Assumes: array byte is a fixed function of its address
// Notes:   expected bytes are queued by the driver, matched as they arrive
`timescale 1ns/1ps
`default_nettype none
module tb_qwr_flash_read;
  import qwr_pkg::*;
  localparam int DC1 = 5;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        qe = 1'b0;
  logic        dc = 1'b0;
  logic        listen = 1'b0;
  logic        oe_seen = 1'b0;
  logic [3:0]  io_w, d_io, d_oe, h_io;
  logic        sclk, cs_n, h_drv, quad_command_mode, skip, wdis;
  logic [1:0]  wlen, dfld;
  logic [23:0] maddr;
  logic [7:0]  mdat;
  logic [6:0]  st;
  logic [7:0]  exp_q[$];
  int          error_cnt = 0;
  int          tests_run = 0;

  function automatic logic [7:0] mem_f(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // array model, wire level and status view
  assign mdat = mem_f(maddr);
  assign io_w = (d_oe[0] === 1'b1) ? d_io : h_io;
  assign st = {quad_command_mode, skip, wdis, wlen, dfld};

  qwr_flash_read #(.P_DC1_DUMMY(DC1)) uut (
    .i_sys_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io_w), .o_io(d_io),
    .o_io_oe(d_oe), .i_quad_lines_enable_bit(qe), .i_dummy_count_select_bit(dc),
    .i_mem_data(mdat), .o_mem_addr(maddr), .o_quad_command_mode(quad_command_mode),
    .o_opcode_skip_armed(skip), .o_wrap_disable_bit(wdis), .o_wrap_length_bits(wlen),
    .o_quad_dummy_count_field(dfld));
  qwr_host_model host (.i_sys_clk(clk), .i_io(io_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io), .o_drv(h_drv));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic nib(input logic [3:0] v, input logic dtr);
    host.half(v, 1'b1);
    if (!dtr) host.half(v, 1'b1);
  endtask

  // opcodes are single edge: eight bits on line zero, or two nibbles
  task automatic op_out(input logic [7:0] op, input logic q);
    for (int i = 7; i >= 0; i -= (q ? 4 : 1)) nib(q ? op[i-:4] : {3'b000, op[i]}, 1'b0);
  endtask

  task automatic cmd(input logic [7:0] op, input logic q, input int mb);
    host.frame(1'b1);
    op_out(op, q);
    if (mb >= 0) op_out(mb[7:0], q);
    host.frame(1'b0);
  endtask

  task automatic set_wrap(input logic [7:0] w);
    logic [31:0] v;
    v = ($urandom() << 8) | w;
    host.frame(1'b1);
    op_out(OP_SET_WRAP, 1'b0);
    for (int i = 31; i >= 0; i--) nib({3'b000, v[i]}, 1'b0);
    host.frame(1'b0);
  endtask

  // ok: 0 skipped opcode, 1 single line, 2 quad; mb below zero means no mode byte
  task automatic rd(input logic [7:0] op, input int ok, input logic [23:0] a, input logic dr,
                    input int mb, input int dum, input int n, input logic [23:0] wm);
    logic [23:0] b;
    b = a;
    for (int i = 0; i < n; i++) begin
      if (listen) exp_q.push_back(mem_f(b));
      b = (wm != 0) ? ((b & ~wm) | ((b + 24'h1) & wm)) : b + 24'h1;
    end
    host.frame(1'b1);
    if (ok > 0) op_out(op, ok == 2);
    for (int i = 5; i >= 0; i--) nib(a[4*i+:4], dr);
    if (mb >= 0) nib(mb[7:4], dr);
    if (mb >= 0) nib(mb[3:0], dr);
    for (int i = 0; i < 2 * dum - 1; i++) host.half(4'h0, 1'b0);
    host.rd(n, dr);
    host.frame(1'b0);
  endtask

  // each collected byte is matched against the oldest note
  always @(host.got) begin
    if (listen) chk(host.rx_byte, exp_q.pop_front());
  end

  // the device may not drive while the host does
  always @(posedge clk) begin
    if (!rst && d_oe !== 4'h0) oe_seen <= 1'b1;  // enables are unknown before the first reset edge
    if (d_oe[0] === 1'b1 && h_drv) chk(1, 0);
  end

  initial begin
    forever #2.5 clk = ~clk;
  end

  // a hang costs a mismatch and ends the run
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end

  initial begin
    logic [23:0] a, wm;
    logic [7:0]  p;
    int          len, nd;
    void'($urandom(85));
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (8) @(negedge clk);
    chk(st, 7'h10);
    $display("test reset done");
    // without quad enable everything here is ignored
    rd(OP_DTR_QIO, 1, 24'h000100, 1'b1, 8'h20, 7, 2, 24'h0);
    rd(OP_WORD_RD, 1, 24'h000200, 1'b0, 8'h20, 2, 2, 24'h0);
    cmd(OP_QPI_ON, 1'b0, -1);
    cmd(OP_SET_PARAM, 1'b0, 8'h33);
    chk(oe_seen, 1'b0);
    chk(st, 7'h10);
    $display("test refusals done");
    @(negedge clk) qe = 1'b1;
    dc = 1'($urandom_range(1));
    nd = dc ? DC1 : 7;
    listen = 1'b1;
    a = 24'($urandom());
    rd(OP_DTR_QIO, 1, a, 1'b1, {2'($urandom()), 2'b10, 4'($urandom())}, nd, 5, 24'h0);
    chk(skip, 1'b1);
    rd(OP_DTR_QIO, 0, a ^ 24'h5A5A5, 1'b1, 8'hF0 | 8'($urandom_range(15)), nd, 3, 24'h0);
    chk(skip, 1'b0);
    rd(OP_DTR_QIO, 1, a + 24'h10, 1'b1, 8'h00, nd, 3, 24'h0);
    $display("test continuous read done");
    len = $urandom_range(3);
    set_wrap({1'b1, 2'(len), 1'b0, 4'($urandom())});
    chk(st, {3'b000, 2'(len), 2'b00});
    wm = (24'h8 << len) - 24'h1;
    // the other dummy select value, so both settings reach the device
    dc = ~dc;
    nd = dc ? DC1 : 7;
    rd(OP_DTR_QIO, 1, a, 1'b1, 8'h00, nd, (8 << len) + 2, wm);
    rd(OP_WORD_RD, 1, a & ~24'h1, 1'b0, 8'h20, 2, (8 << len) + 1, wm);
    chk(skip, 1'b1);
    rd(OP_WORD_RD, 0, (a ^ 24'h0F0F0) & ~24'h1, 1'b0, 8'h30, 2, 3, wm);
    chk(skip, 1'b0);
    // re-arm, then all-ones on line zero fills address and mode and disarms
    rd(OP_WORD_RD, 1, a & ~24'h1, 1'b0, 8'h20, 2, 1, wm);
    chk(skip, 1'b1);
    cmd(8'hFF, 1'b0, -1);
    chk(skip, 1'b0);
    $display("test wrap done");
    cmd(OP_QPI_ON, 1'b0, -1);
    chk(st, {3'b100, 2'(len), 2'b00});
    // every dummy code, each followed by a wrapped burst read
    for (int i = 0; i < 4; i++) begin
      p = {2'($urandom()), 2'(i), 2'($urandom()), 2'($urandom())};
      cmd(OP_SET_PARAM, 1'b1, p);
      chk({wlen, dfld}, {p[1:0], p[5:4]});
      nd = (i == 0) ? 10 : 2 + 2 * i;
      wm = (24'h8 << p[1:0]) - 24'h1;
      rd(OP_BURST_WRAP, 2, a, 1'b0, -1, nd, (8 << p[1:0]) + 1, wm);
    end
    rd(OP_DTR_QIO, 2, a | 24'h3E, 1'b1, 8'h00, nd - 1, 4, 24'h0);
    rd(OP_DTR_WRAP, 2, a, 1'b1, -1, nd, (8 << p[1:0]) + 2, wm);
    cmd(OP_QPI_OFF, 1'b1, -1);
    chk(quad_command_mode, 1'b0);
    chk(exp_q.size(), 0);
    $display("test quad mode done");
    summarize();
  end
endmodule
`default_nettype wire
